// *** hw/lpe_defines.svh ***
`ifndef LPE_DEFINES_SVH
`define LPE_DEFINES_SVH

// ****************************************************************
// line and register selection
// ****************************************************************
`define LPE_NLINES       16
`define LPE_REG_TX_ACC   4'h6
`define LPE_REG_RX_ACC   4'h7
`define LPE_REG_BASE     4'h8
`define LPE_REG_LPR      4'ha
`define LPE_REG_LSTATE   4'hb
`define LPE_REG_TX_MODE  4'hc
`define LPE_REG_RX_MODE  4'hd

// ****************************************************************
// line protocol parameter fields
// ****************************************************************
`define LPE_LPR_IDLE_MARK 0
`define LPE_LPR_STRIP     1
`define LPE_LPR_CHK_LSB   3
`define LPE_LPR_CHK_MSB   4
`define LPE_LPR_RX_BYP    5
`define LPE_LPR_TX_BYP    6
`define LPE_LPR_ESC_LSB   8
`define LPE_LPR_ESC_MSB   15

// ****************************************************************
// line state scorecard fields
// ****************************************************************
`define LPE_LS_ACTIVE     0
`define LPE_LS_RESYNC     1
`define LPE_LS_GO         2
`define LPE_LS_UNDERRUN   3
`define LPE_LS_NXM        4
`define LPE_LS_MPE        5
`define LPE_LS_STRIP_ON   6
`define LPE_LS_ALT        7
`define LPE_LS_EXPECT     10
`define LPE_LS_NMODE_LSB  13
`define LPE_LS_NMODE_MSB  15
`define LPE_LS_HOST_MASK  16'he4be

// ****************************************************************
// control byte fields and block check codes
// ****************************************************************
`define LPE_CTL_ESC       1
`define LPE_CTL_INCL      3
`define LPE_CHK_LRC       2'h0
`define LPE_CHK_CRC16     2'h1
`define LPE_CHK_CCITT     2'h3
`define LPE_POLY_CRC16    16'ha001
`define LPE_POLY_CCITT    16'h8408
`define LPE_RESET_ZERO    16'h0000

`endif

// *** hw/lpe_pkg.sv ***
`include "lpe_defines.svh"

package lpe_pkg;

    typedef enum logic [5:0] {
        TX_IDLE   = 6'h01,
        TX_FETCH  = 6'h02,
        TX_ESC    = 6'h04,
        TX_CHAR   = 6'h08,
        TX_CHK_LO = 6'h10,
        TX_CHK_HI = 6'h20
    } lpe_tx_state_t;

    typedef struct packed {
        lpe_tx_state_t        fsm;
        logic [15:0][15:0]    rx_acc;
        logic [15:0][15:0]    tx_acc;
        logic [15:0][15:0]    line_protocol_parameters;
        logic [15:0][15:0]    lstate;
        logic [15:0][17:0]    base;
        logic [15:0][2:0]     rx_mode;
        logic [15:0][2:0]     tx_mode;
        logic [15:0]          expect_chk;
        logic [15:0]          idle_mark;
        logic [15:0]          flag_pend;
        logic [1:0][11:0]     buf_d;
        logic [1:0]           buf_cnt;
        logic [3:0]           t_line;
        logic [7:0]           t_char;
        logic                 t_incl;
        logic [17:0]          fetch_addr;
        logic [15:0]          rdata;
        logic                 st_valid;
        logic [3:0]           st_line;
        logic [7:0]           st_char;
        logic                 st_first;
        logic                 rs_valid;
        logic [3:0]           rs_line;
    } lpe_state_t;

endpackage

// *** hw/lpe_check_step.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "lpe_defines.svh"

// ****************************************************************
// one whole byte folded into a block check
// ****************************************************************
module lpe_check_step (
    // accumulator in
    input  wire logic [15:0] i_acc,
    input  wire logic [7:0]  i_char,
    input  wire logic [1:0]  i_type,
    // accumulator out
    output logic      [15:0] o_acc
);

    logic [15:0] poly;
    logic [15:0] crc;

    always_comb begin
        poly = (i_type == `LPE_CHK_CCITT) ? `LPE_POLY_CCITT
                                          : `LPE_POLY_CRC16;
        crc = i_acc;
        for (int b = 0; b < 8; b++) begin
            if (crc[0] ^ i_char[b]) begin
                crc = (crc >> 1) ^ poly;
            end else begin
                crc = crc >> 1;
            end
        end
        case (i_type)
            `LPE_CHK_LRC:   o_acc = {i_acc[15:8], i_acc[7:0] ^ i_char};
            `LPE_CHK_CRC16: o_acc = crc;
            `LPE_CHK_CCITT: o_acc = crc;
            default:        o_acc = i_acc;
        endcase
    end

endmodule

`default_nettype wire

// *** hw/lpe_line_engine.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "lpe_defines.svh"

module lpe_line_engine (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // host indirect access
    input  wire logic [3:0]  i_acc_line,
    input  wire logic [3:0]  i_acc_reg,
    input  wire logic        i_acc_wr,
    input  wire logic        i_acc_rd,
    input  wire logic [15:0] i_acc_wdata,
    input  wire logic [1:0]  i_scr_ext,
    output logic      [15:0] o_acc_rdata,
    // line configuration
    input  wire logic [15:0] i_line_sync,
    // receiver events
    input  wire logic        i_rx_valid,
    input  wire logic [3:0]  i_rx_line,
    input  wire logic [7:0]  i_rx_char,
    input  wire logic [7:0]  i_rx_ctl,
    input  wire logic        i_rx_is_sync,
    input  wire logic        i_rx_bc_zero,
    input  wire logic        i_rx_bc_marked,
    input  wire logic        i_rx_sync_met,
    input  wire logic [3:0]  i_rx_sync_line,
    input  wire logic        i_rx_enabled,
    input  wire logic        i_flag_found,
    input  wire logic [3:0]  i_flag_line,
    // received character store
    output logic             o_st_valid,
    output logic      [3:0]  o_st_line,
    output logic      [7:0]  o_st_char,
    output logic             o_st_first_check,
    // resync pulse and flag pending levels
    output logic             o_resync_valid,
    output logic      [3:0]  o_resync_line,
    output logic      [15:0] o_flag_pending,
    // transmit requests
    input  wire logic        i_tx_valid,
    input  wire logic [3:0]  i_tx_line,
    input  wire logic [7:0]  i_tx_char,
    input  wire logic        i_tx_check,
    output logic             o_tx_ready,
    // control byte fetch
    output logic             o_fetch_valid,
    output logic      [17:0] o_fetch_addr,
    input  wire logic        i_fetch_ack,
    input  wire logic [7:0]  i_fetch_ctl,
    // transmit status events
    input  wire logic        i_tx_evt,
    input  wire logic [3:0]  i_tx_evt_line,
    input  wire logic        i_tx_nxm,
    input  wire logic        i_tx_mpe,
    input  wire logic        i_tx_underrun,
    input  wire logic        i_tx_runout,
    input  wire logic        i_tx_other_zero,
    // outgoing characters
    output logic             o_out_valid,
    input  wire logic        i_out_ready,
    output logic      [3:0]  o_out_line,
    output logic      [7:0]  o_out_char,
    // line levels
    output logic      [15:0] o_tx_go,
    output logic      [15:0] o_rx_active,
    output logic      [15:0] o_idle_mark
);

    lpe_pkg::lpe_state_t s_r;
    lpe_pkg::lpe_state_t s_nxt;
    logic [15:0]         rx_step;
    logic [15:0]         tx_step;

    // ****************************************************************
    // block check steps
    // ****************************************************************
    lpe_check_step u_rx_step (
        .i_acc  (s_r.rx_acc[i_rx_line]),
        .i_char (i_rx_char),
        .i_type (s_r.line_protocol_parameters[i_rx_line][`LPE_LPR_CHK_MSB:`LPE_LPR_CHK_LSB]),
        .o_acc  (rx_step)
    );

    lpe_check_step u_tx_step (
        .i_acc  (s_r.tx_acc[s_r.t_line]),
        .i_char (s_r.t_char),
        .i_type (s_r.line_protocol_parameters[s_r.t_line][`LPE_LPR_CHK_MSB:`LPE_LPR_CHK_LSB]),
        .o_acc  (tx_step)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic        pop;
        logic        push;
        logic [11:0] pdata;
        logic        found;
        logic [3:0]  l;
        logic        strip;
        logic        incl;
        logic [1:0]  ctype;
        logic [1:0]  wptr;
        pop   = 1'b0;
        push  = 1'b0;
        pdata = 12'h000;
        found = 1'b0;
        l     = 4'h0;
        strip = 1'b0;
        incl  = 1'b0;
        ctype = 2'h0;
        wptr  = 2'h0;
        s_nxt = s_r;
        s_nxt.st_valid = 1'b0;
        s_nxt.st_first = 1'b0;
        s_nxt.rs_valid = 1'b0;

        // host access
        if (i_acc_rd) begin
            case (i_acc_reg)
                `LPE_REG_TX_ACC:  s_nxt.rdata = s_r.tx_acc[i_acc_line];
                `LPE_REG_RX_ACC:  s_nxt.rdata = s_r.rx_acc[i_acc_line];
                `LPE_REG_BASE:    s_nxt.rdata = s_r.base[i_acc_line][15:0];
                `LPE_REG_LPR:     s_nxt.rdata = s_r.line_protocol_parameters[i_acc_line];
                `LPE_REG_LSTATE:  s_nxt.rdata = s_r.lstate[i_acc_line];
                `LPE_REG_TX_MODE: s_nxt.rdata = {13'h0000, s_r.tx_mode[i_acc_line]};
                `LPE_REG_RX_MODE: s_nxt.rdata = {13'h0000, s_r.rx_mode[i_acc_line]};
                default:          s_nxt.rdata = `LPE_RESET_ZERO;
            endcase
        end
        if (i_acc_wr) begin
            case (i_acc_reg)
                `LPE_REG_TX_ACC:  s_nxt.tx_acc[i_acc_line] = i_acc_wdata;
                `LPE_REG_RX_ACC:  s_nxt.rx_acc[i_acc_line] = i_acc_wdata;
                `LPE_REG_BASE:    s_nxt.base[i_acc_line] = {i_scr_ext, i_acc_wdata};
                `LPE_REG_LPR:     s_nxt.line_protocol_parameters[i_acc_line] = i_acc_wdata;
                `LPE_REG_LSTATE:  s_nxt.lstate[i_acc_line] =
                    (s_r.lstate[i_acc_line] & ~`LPE_LS_HOST_MASK) |
                    (i_acc_wdata & `LPE_LS_HOST_MASK);
                `LPE_REG_TX_MODE: s_nxt.tx_mode[i_acc_line] = i_acc_wdata[2:0];
                `LPE_REG_RX_MODE: s_nxt.rx_mode[i_acc_line] = i_acc_wdata[2:0];
                default:          s_nxt.rdata = s_nxt.rdata;
            endcase
        end

        // receiver synchronization
        if (i_rx_sync_met && i_rx_enabled) begin
            s_nxt.lstate[i_rx_sync_line][`LPE_LS_ACTIVE] = 1'b1;
            if (i_line_sync[i_rx_sync_line] &&
                s_r.line_protocol_parameters[i_rx_sync_line][`LPE_LPR_STRIP]) begin
                s_nxt.lstate[i_rx_sync_line][`LPE_LS_STRIP_ON] = 1'b1;
            end
        end

        // received character
        if (i_rx_valid) begin
            l = i_rx_line;
            strip = s_r.lstate[l][`LPE_LS_STRIP_ON] && i_rx_is_sync;
            if (!i_rx_is_sync) begin
                s_nxt.lstate[l][`LPE_LS_STRIP_ON] = 1'b0;
            end
            if (s_r.line_protocol_parameters[l][`LPE_LPR_RX_BYP] && s_r.rx_mode[l] == 3'h0) begin
                incl = !strip;
            end else begin
                incl = !strip && i_rx_ctl[`LPE_CTL_INCL];
            end
            if (!strip) begin
                s_nxt.st_valid = 1'b1;
                s_nxt.st_line  = l;
                s_nxt.st_char  = i_rx_char;
                s_nxt.st_first = s_r.expect_chk[l];
                s_nxt.expect_chk[l] = 1'b0;
            end
            if (incl && !(i_acc_wr && i_acc_reg == `LPE_REG_RX_ACC &&
                          i_acc_line == l)) begin
                s_nxt.rx_acc[l] = rx_step;
            end
            if (i_rx_bc_zero && i_rx_bc_marked) begin
                s_nxt.rx_mode[l] = s_r.lstate[l]
                    [`LPE_LS_NMODE_MSB:`LPE_LS_NMODE_LSB];
                if (s_r.lstate[l][`LPE_LS_EXPECT]) begin
                    s_nxt.expect_chk[l] = 1'b1;
                end
            end
        end

        // resynchronize request, lowest line first
        for (int i = 0; i < `LPE_NLINES; i++) begin
            if (!found && s_r.lstate[i][`LPE_LS_RESYNC]) begin
                found = 1'b1;
                s_nxt.lstate[i][`LPE_LS_RESYNC] = 1'b0;
                s_nxt.lstate[i][`LPE_LS_ACTIVE] = 1'b0;
                s_nxt.lstate[i][`LPE_LS_STRIP_ON] = 1'b0;
                s_nxt.flag_pend[i] = 1'b1;
                s_nxt.rs_valid = 1'b1;
                s_nxt.rs_line  = 4'(i);
            end
        end
        if (i_flag_found && !(found && s_nxt.rs_line == i_flag_line)) begin
            s_nxt.flag_pend[i_flag_line] = 1'b0;
        end

        // transmit status events
        if (i_tx_evt) begin
            l = i_tx_evt_line;
            if (i_tx_nxm) begin
                s_nxt.lstate[l][`LPE_LS_NXM] = 1'b1;
                s_nxt.lstate[l][`LPE_LS_GO]  = 1'b0;
            end
            if (i_tx_mpe) begin
                s_nxt.lstate[l][`LPE_LS_MPE] = 1'b1;
                s_nxt.lstate[l][`LPE_LS_GO]  = 1'b0;
            end
            if (i_tx_underrun && i_line_sync[l]) begin
                s_nxt.lstate[l][`LPE_LS_UNDERRUN] = 1'b1;
            end
            if (i_tx_runout) begin
                if (i_tx_other_zero) begin
                    s_nxt.lstate[l][`LPE_LS_GO] = 1'b0;
                    s_nxt.idle_mark[l] = i_line_sync[l]
                        ? s_r.line_protocol_parameters[l][`LPE_LPR_IDLE_MARK] : 1'b1;
                end else begin
                    s_nxt.lstate[l][`LPE_LS_ALT] =
                        !s_r.lstate[l][`LPE_LS_ALT];
                end
            end
        end
        for (int i = 0; i < `LPE_NLINES; i++) begin
            if (!s_r.lstate[i][`LPE_LS_GO] && s_nxt.lstate[i][`LPE_LS_GO]) begin
                s_nxt.idle_mark[i] = 1'b0;
            end
        end

        // output buffer drain
        pop = (s_r.buf_cnt != 2'h0) && i_out_ready;
        if (pop) begin
            s_nxt.buf_d[0] = s_r.buf_d[1];
        end

        // transmit sequencer
        ctype = s_r.line_protocol_parameters[s_r.t_line][`LPE_LPR_CHK_MSB:`LPE_LPR_CHK_LSB];
        case (s_r.fsm)
            lpe_pkg::TX_IDLE: begin
                if (i_tx_valid) begin
                    s_nxt.t_line = i_tx_line;
                    s_nxt.t_char = i_tx_char;
                    s_nxt.fetch_addr = s_r.base[i_tx_line] +
                        {7'h00, s_r.tx_mode[i_tx_line], i_tx_char};
                    if (i_tx_check) begin
                        s_nxt.fsm = lpe_pkg::TX_CHK_LO;
                    end else if (s_r.line_protocol_parameters[i_tx_line][`LPE_LPR_TX_BYP] &&
                                 s_r.tx_mode[i_tx_line] == 3'h0) begin
                        s_nxt.t_incl = 1'b1;
                        s_nxt.fsm = lpe_pkg::TX_CHAR;
                    end else begin
                        s_nxt.fsm = lpe_pkg::TX_FETCH;
                    end
                end
            end
            lpe_pkg::TX_FETCH: begin
                if (i_fetch_ack) begin
                    s_nxt.t_incl = i_fetch_ctl[`LPE_CTL_INCL];
                    s_nxt.fsm = i_fetch_ctl[`LPE_CTL_ESC]
                        ? lpe_pkg::TX_ESC : lpe_pkg::TX_CHAR;
                end
            end
            lpe_pkg::TX_ESC: begin
                push  = 1'b1;
                pdata = {s_r.t_line,
                         s_r.line_protocol_parameters[s_r.t_line][`LPE_LPR_ESC_MSB:`LPE_LPR_ESC_LSB]};
            end
            lpe_pkg::TX_CHAR: begin
                push  = 1'b1;
                pdata = {s_r.t_line, s_r.t_char};
            end
            lpe_pkg::TX_CHK_LO: begin
                push  = 1'b1;
                pdata = {s_r.t_line, s_r.tx_acc[s_r.t_line][7:0]};
            end
            lpe_pkg::TX_CHK_HI: begin
                push  = 1'b1;
                pdata = {s_r.t_line, s_r.tx_acc[s_r.t_line][15:8]};
            end
            default: begin
                s_nxt.fsm = lpe_pkg::TX_IDLE;
            end
        endcase
        if (push && (s_r.buf_cnt != 2'h2 || pop)) begin
            wptr = s_r.buf_cnt - {1'b0, pop};
            s_nxt.buf_d[wptr[0]] = pdata;
            s_nxt.buf_cnt = s_r.buf_cnt + 2'h1 - {1'b0, pop};
            case (s_r.fsm)
                lpe_pkg::TX_ESC: begin
                    s_nxt.fsm = lpe_pkg::TX_CHAR;
                end
                lpe_pkg::TX_CHAR: begin
                    if (s_r.t_incl) begin
                        s_nxt.tx_acc[s_r.t_line] = tx_step;
                    end
                    s_nxt.t_incl = 1'b0;
                    s_nxt.fsm = lpe_pkg::TX_IDLE;
                end
                lpe_pkg::TX_CHK_LO: begin
                    if (ctype == `LPE_CHK_LRC) begin
                        s_nxt.tx_acc[s_r.t_line] = `LPE_RESET_ZERO;
                        s_nxt.fsm = lpe_pkg::TX_IDLE;
                    end else begin
                        s_nxt.fsm = lpe_pkg::TX_CHK_HI;
                    end
                end
                default: begin
                    s_nxt.tx_acc[s_r.t_line] = `LPE_RESET_ZERO;
                    s_nxt.fsm = lpe_pkg::TX_IDLE;
                end
            endcase
        end else if (pop) begin
            s_nxt.buf_cnt = s_r.buf_cnt - 2'h1;
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s_r     <= '0;
            s_r.fsm <= lpe_pkg::TX_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    always_comb begin
        o_acc_rdata      = s_r.rdata;
        o_st_valid       = s_r.st_valid;
        o_st_line        = s_r.st_line;
        o_st_char        = s_r.st_char;
        o_st_first_check = s_r.st_first;
        o_resync_valid   = s_r.rs_valid;
        o_resync_line    = s_r.rs_line;
        o_flag_pending   = s_r.flag_pend;
        o_tx_ready       = (s_r.fsm == lpe_pkg::TX_IDLE);
        o_fetch_valid    = (s_r.fsm == lpe_pkg::TX_FETCH);
        o_fetch_addr     = s_r.fetch_addr;
        o_out_valid      = (s_r.buf_cnt != 2'h0);
        o_out_line       = s_r.buf_d[0][11:8];
        o_out_char       = s_r.buf_d[0][7:0];
        o_idle_mark      = s_r.idle_mark;
        for (int i = 0; i < `LPE_NLINES; i++) begin
            o_tx_go[i]     = s_r.lstate[i][`LPE_LS_GO];
            o_rx_active[i] = s_r.lstate[i][`LPE_LS_ACTIVE];
        end
    end

endmodule

`default_nettype wire

// *** bench/lpe_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
// ********************
// port checks
// ********************
module lpe_checker (
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_sys_rst,
    // watched ports
    input wire logic        i_acc_wr,
    input wire logic        i_rx_valid,
    input wire logic        i_rx_is_sync,
    input wire logic [7:0]  i_rx_char,
    input wire logic        o_st_valid,
    input wire logic [7:0]  o_st_char,
    input wire logic        o_fetch_valid,
    input wire logic        i_fetch_ack,
    input wire logic        o_tx_ready,
    input wire logic        o_out_valid,
    input wire logic        i_out_ready,
    input wire logic [7:0]  o_out_char,
    input wire logic        i_tx_evt,
    input wire logic [3:0]  i_tx_evt_line,
    input wire logic        i_tx_nxm,
    input wire logic [15:0] o_tx_go,
    input wire logic        i_rx_sync_met,
    input wire logic [3:0]  i_rx_sync_line,
    input wire logic        i_rx_enabled,
    input wire logic [15:0] o_rx_active
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    property p_st;
        o_st_valid |-> $past(i_rx_valid) && o_st_char == $past(i_rx_char);
    endproperty
    a_st: assert property (p_st) else $error("bad store");
    property p_keep;
        i_rx_valid && !i_rx_is_sync |=> o_st_valid;
    endproperty
    a_keep: assert property (p_keep) else $error("char lost");
    property p_fetch;
        o_fetch_valid |-> !o_tx_ready;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch idle");
    property p_wait;
        o_fetch_valid && !i_fetch_ack |=> o_fetch_valid;
    endproperty
    a_wait: assert property (p_wait) else $error("fetch drop");
    property p_hold;
        o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_char);
    endproperty
    a_hold: assert property (p_hold) else $error("out moved");
    property p_go;
        i_tx_evt && i_tx_nxm && !i_acc_wr |=> !o_tx_go[$past(i_tx_evt_line)];
    endproperty
    a_go: assert property (p_go) else $error("go kept");
    property p_gochg;
        o_tx_go != $past(o_tx_go) |-> $past(i_acc_wr) || $past(i_tx_evt);
    endproperty
    a_gochg: assert property (p_gochg) else $error("go moved");
    property p_act;
        i_rx_sync_met && i_rx_enabled |=> o_rx_active[$past(i_rx_sync_line)];
    endproperty
    a_act: assert property (p_act) else $error("not active");
endmodule
bind lpe_line_engine lpe_checker u_chk (.*);
`default_nettype wire

// *** bench/lpe_far_side.sv ***
`timescale 1ns/100ps
`default_nettype none
// ********************
// control bytes and sink
// ********************
module lpe_far_side (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    // bench controls
    input  wire logic       i_hold,
    input  wire logic [7:0] i_ctl,
    // fetch and sink
    input  wire logic       i_fetch_valid,
    output logic            o_fetch_ack,
    output logic      [7:0] o_fetch_ctl,
    output logic            o_out_ready
);
    logic [1:0] wait_r;
    logic       ack_nxt;
    assign ack_nxt = i_fetch_valid && !o_fetch_ack && wait_r == 2'h2;
    initial {o_fetch_ack, o_fetch_ctl, o_out_ready, wait_r} = '0;
    always @(posedge i_clk) begin
        o_out_ready <= !i_hold && !i_sys_rst;
        wait_r <= (i_fetch_valid && !ack_nxt) ? wait_r + 2'h1 : 2'h0;
        o_fetch_ack <= ack_nxt;
        o_fetch_ctl <= ack_nxt ? i_ctl : ~o_fetch_ctl;
    end
endmodule
`default_nettype wire

// *** bench/line_protocol_engine_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
// ********************
// line engine bench
// ********************
module line_protocol_engine_tb;
    logic        i_clk, i_sys_rst, i_acc_wr, i_acc_rd, i_rx_valid, hold;
    logic        i_rx_is_sync, i_rx_bc_zero, i_rx_bc_marked, i_rx_sync_met;
    logic        i_rx_enabled, i_flag_found, i_tx_valid, i_tx_check, i_tx_evt;
    logic        i_tx_nxm, i_tx_mpe, i_tx_underrun, i_tx_runout;
    logic        i_tx_other_zero, o_st_valid, o_st_first_check;
    logic        o_resync_valid, o_tx_ready, o_fetch_valid, i_fetch_ack;
    logic        o_out_valid, i_out_ready;
    logic [1:0]  i_scr_ext, s;
    logic [3:0]  i_acc_line, i_acc_reg, i_rx_line, i_rx_sync_line, rl;
    logic [3:0]  i_flag_line, i_tx_line, i_tx_evt_line, o_st_line;
    logic [3:0]  o_resync_line, o_out_line;
    logic [7:0]  i_rx_char, i_rx_ctl, i_tx_char, ctl, o_st_char, o_out_char;
    logic [7:0]  i_fetch_ctl;
    logic [15:0] i_acc_wdata, i_line_sync, o_acc_rdata, o_flag_pending, v;
    logic [15:0] o_tx_go, o_rx_active, o_idle_mark;
    logic [17:0] o_fetch_addr, fa;
    logic [7:0]  got[$];
    int          errors, samples_checked, cycles;
    localparam logic [47:0] ROWS [6] = '{48'h0020_00_5a_005a,
        48'h0028_00_01_c0c1, 48'h0038_00_01_1189, 48'h0030_00_01_0000,
        48'h0000_08_33_0033, 48'h0000_00_33_0000};
    lpe_line_engine u_dut (.*);
    lpe_far_side u_far (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hold(hold),
        .i_ctl(ctl), .i_fetch_valid(o_fetch_valid), .o_fetch_ack(i_fetch_ack),
        .o_fetch_ctl(i_fetch_ctl), .o_out_ready(i_out_ready));
    always #4 i_clk = ~i_clk;
    task automatic check(input string n, input logic [23:0] e, g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic acc(input logic [3:0] l, r, input logic w,
                       input logic [15:0] d);
        @(posedge i_clk);
        {i_acc_line, i_acc_reg, i_acc_wr, i_acc_rd, i_acc_wdata} <=
            {l, r, w, !w, d};
        @(posedge i_clk);
        {i_acc_wr, i_acc_rd} <= 2'b00;
        @(posedge i_clk);
        v = o_acc_rdata;
    endtask
    task automatic rx(input logic [3:0] l, input logic [7:0] c, k,
                      input logic z);
        @(posedge i_clk);
        {i_rx_valid, i_rx_line, i_rx_char, i_rx_ctl} <= {1'b1, l, c, k};
        {i_rx_bc_zero, i_rx_bc_marked} <= {z, z};
        @(posedge i_clk);
        {i_rx_valid, i_rx_bc_zero, i_rx_bc_marked} <= 3'b000;
        @(posedge i_clk);
        s = {o_st_valid, o_st_first_check};
    endtask
    task automatic tx(input logic [3:0] l, input logic [7:0] c,
                      input logic k);
        @(posedge i_clk);
        {i_tx_valid, i_tx_line, i_tx_char, i_tx_check} <= {1'b1, l, c, k};
        do @(posedge i_clk); while (o_tx_ready !== 1'b1);
        i_tx_valid <= 1'b0;
    endtask
    task automatic evt(input logic [3:0] l, q);
        @(posedge i_clk);
        {i_tx_evt, i_tx_evt_line, i_tx_nxm, i_tx_underrun, i_tx_runout,
         i_tx_other_zero} <= {1'b1, l, q};
        @(posedge i_clk);
        i_tx_evt <= 1'b0;
        @(posedge i_clk);
    endtask
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (o_out_valid && i_out_ready) got.push_back(o_out_char);
        if (o_fetch_valid && i_fetch_ack) fa <= o_fetch_addr;
        if (o_resync_valid) rl <= o_resync_line;
        if (cycles == 5000) begin
            errors++;
            close_out();
        end
    end
    initial begin
        {i_clk, i_acc_wr, i_acc_rd, i_rx_valid, hold, i_rx_is_sync,
         i_rx_bc_zero, i_rx_bc_marked, i_rx_sync_met, i_rx_enabled,
         i_flag_found, i_tx_valid, i_tx_check, i_tx_evt, i_tx_nxm, i_tx_mpe,
         i_tx_underrun, i_tx_runout, i_tx_other_zero, i_scr_ext, i_acc_line,
         i_acc_reg, i_rx_line, i_rx_sync_line, i_flag_line, i_tx_line,
         i_tx_evt_line, i_rx_char, i_rx_ctl, i_tx_char, ctl, i_acc_wdata,
         i_line_sync, rl, fa} = '0;
        i_sys_rst = 1'b1;
        repeat (16) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        #1 check("reset", 24'h80, {o_tx_go, o_tx_ready, o_out_valid, 6'h0});
        for (int i = 0; i < 6; i++) begin
            acc(i[3:0], 4'h7, 1'b1, 16'h0000);
            acc(i[3:0], 4'ha, 1'b1, ROWS[i][47:32]);
            rx(i[3:0], ROWS[i][23:16], ROWS[i][31:24], 1'b0);
            acc(i[3:0], 4'h7, 1'b0, 16'h0000);
            check("rx_acc", {8'h0, ROWS[i][15:0]}, {8'h0, v});
        end
        $display("check rows done");
        acc(4'h2, 4'ha, 1'b1, 16'h0048);
        hold <= 1'b1;
        tx(4'h2, 8'h01, 1'b0);
        tx(4'h2, 8'h00, 1'b1);
        repeat (8) @(posedge i_clk);
        hold <= 1'b0;
        repeat (8) @(posedge i_clk);
        check("tx_seq", 24'h01c1c0, {got[0], got[1], got[2]});
        acc(4'h2, 4'h6, 1'b0, 16'h0000);
        check("tx_acc", 24'h0, {8'h0, v});
        got.delete();
        {i_scr_ext, ctl} <= {2'h1, 8'h02};
        acc(4'h3, 4'h8, 1'b1, 16'h0100);
        acc(4'h3, 4'ha, 1'b1, 16'h1000);
        tx(4'h3, 8'h41, 1'b0);
        repeat (12) @(posedge i_clk);
        check("fetch_addr", 24'h010141, {6'h0, fa});
        check("esc_seq", 24'h1041, {8'h0, got[0], got[1]});
        $display("transmit done");
        acc(4'h1, 4'hb, 1'b1, 16'h0004);
        evt(4'h1, 4'b1100);
        acc(4'h1, 4'hb, 1'b0, 16'h0000);
        check("state_nxm", 24'h0010, {8'h0, v});
        acc(4'h1, 4'hb, 1'b1, 16'h0004);
        evt(4'h1, 4'b0010);
        acc(4'h1, 4'hb, 1'b0, 16'h0000);
        check("state_alt", 24'h0084, {8'h0, v});
        evt(4'h1, 4'b0011);
        check("idle", 24'h1, {o_tx_go[1], o_idle_mark[1]});
        $display("status done");
        i_line_sync <= 16'h0020;
        acc(4'h5, 4'ha, 1'b1, 16'h0002);
        rx(4'h5, 8'h00, 8'h00, 1'b0);
        {i_rx_sync_met, i_rx_sync_line, i_rx_enabled} <= {1'b1, 4'h5, 1'b1};
        @(posedge i_clk);
        {i_rx_sync_met, i_rx_is_sync} <= 2'b01;
        rx(4'h5, 8'h16, 8'h00, 1'b0);
        i_rx_is_sync <= 1'b0;
        check("strip", 24'h0, {22'h0, s});
        acc(4'h5, 4'hb, 1'b1, 16'h0002);
        repeat (4) @(posedge i_clk);
        check("resync", 24'h15, {o_rx_active[5], o_flag_pending[5], rl});
        acc(4'h4, 4'hb, 1'b1, 16'h6400);
        rx(4'h4, 8'h11, 8'h00, 1'b1);
        rx(4'h4, 8'h22, 8'h00, 1'b0);
        check("first_check", 24'h3, {22'h0, s});
        acc(4'h4, 4'hd, 1'b0, 16'h0000);
        check("rx_mode", 24'h3, {8'h0, v});
        $display("receive done");
        close_out();
    end
endmodule
`default_nettype wire
